// ### core/fws_bus.sv
// Single read or write cycle engine on the flash strobes
`timescale 1ns/1ns
`default_nettype none
module fws_bus (
   input wire logic clk,
   input wire logic resetn,
   input wire logic req,
   input wire logic req_we,
   input wire logic [fws_pkg::ADDR_W-1:0] req_addr,
   input wire logic [fws_pkg::DATA_W-1:0] req_data,
   output logic ack,
   output logic [fws_pkg::DATA_W-1:0] rdata,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [fws_pkg::ADDR_W-1:0] addr,
   output logic [fws_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [fws_pkg::DATA_W-1:0] dq_in
);
   typedef struct packed {
      fws_pkg::fws_bus_state_e st;
      logic [3:0] cnt;
      logic wr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [fws_pkg::ADDR_W-1:0] addr;
      logic [fws_pkg::DATA_W-1:0] dout;
      logic dq_oe;
      logic ack;
      logic [fws_pkg::DATA_W-1:0] rdata;
   } fws_bus_s;

   fws_bus_s b_reg;
   fws_bus_s b_next;

   ////////////////////////////////////////////////////////////////////////
   // Next state: strobes asserted together; we_n released a cycle before ce_n and oe_n
   always_comb begin
      b_next = b_reg;
      b_next.ack = 1'b0;
      case (b_reg.st)
         fws_pkg::BS_IDLE: begin
            // Requests only taken here; a request while busy is lost
            if (req) begin
               b_next.st = fws_pkg::BS_ACT;
               b_next.cnt = 4'h0;
               b_next.wr = req_we;
               b_next.addr = req_addr;
               b_next.dout = req_data;
               b_next.ce_n = 1'b0;
               b_next.oe_n = req_we;
               b_next.we_n = !req_we;
               b_next.dq_oe = req_we;
            end
         end
         fws_pkg::BS_ACT: begin
            if (b_reg.wr && b_reg.cnt == fws_pkg::WP_LAST) begin
               b_next.we_n = 1'b1; // Data latched on this rising edge
               b_next.st = fws_pkg::BS_END;
            end else if (!b_reg.wr && b_reg.cnt == fws_pkg::ACC_LAST) begin
               b_next.rdata = dq_in; // Access time met
               b_next.st = fws_pkg::BS_END;
            end else begin
               b_next.cnt = b_reg.cnt + 4'h1;
            end
         end
         fws_pkg::BS_END: begin
            // One cycle of data hold before the bus is released
            b_next.ce_n = 1'b1;
            b_next.oe_n = 1'b1;
            b_next.dq_oe = 1'b0;
            b_next.ack = 1'b1;
            b_next.st = fws_pkg::BS_IDLE;
         end
         default: begin
            b_next.st = fws_pkg::BS_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         b_reg <= '0;
         b_reg.ce_n <= 1'b1;
         b_reg.oe_n <= 1'b1;
         b_reg.we_n <= 1'b1;
      end else begin
         b_reg <= b_next;
      end
   end

   assign ack = b_reg.ack;
   assign rdata = b_reg.rdata;
   assign ce_n = b_reg.ce_n;
   assign oe_n = b_reg.oe_n;
   assign we_n = b_reg.we_n;
   assign addr = b_reg.addr;
   assign dq_out = b_reg.dout;
   assign dq_oe = b_reg.dq_oe;
endmodule : fws_bus
`default_nettype wire

// ### core/fws_ctrl.sv
// Host controller: toggle polling, failure reset, sector-add window check
`timescale 1ns/1ns
`default_nettype none
// Function
// - Host reads status twice in a row; unchanged toggle means finished.
// - Toggling with timeout flag high: recheck once; still toggling fails.
// - Host resuming polling restarts from the first double read.
// - After any timeout failure host writes the reset command.
// - Host may ignore window flag only with adds under 50 us apart; this host always checks it.
// - Host checks window flag before and after each added sector.
// - Host polls at the program address or a sector being erased.
// - Reset command is a single write of F0 to any address.
module fws_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start_poll,
   input wire logic [fws_pkg::ADDR_W-1:0] poll_addr,
   input wire logic stop_poll,
   input wire logic add_sector,
   input wire logic write_req,
   input wire logic [fws_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [fws_pkg::DATA_W-1:0] cmd_data,
   output logic busy,
   output logic op_done,
   output logic op_failed,
   output logic add_done,
   output logic add_rejected,
   output logic sector_erasing,
   output logic [fws_pkg::DATA_W-1:0] last_status,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [fws_pkg::ADDR_W-1:0] flash_addr,
   output logic [fws_pkg::DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [fws_pkg::DATA_W-1:0] flash_dq_in
);
   typedef struct packed {
      fws_pkg::fws_state_e st;
      logic issued;
      logic req;
      logic we;
      logic [fws_pkg::ADDR_W-1:0] addr;
      logic [fws_pkg::DATA_W-1:0] wdata;
      logic [fws_pkg::DATA_W-1:0] first;
      logic polling;
      logic stop;
      logic busy;
      logic op_done;
      logic op_failed;
      logic add_done;
      logic add_rejected;
      logic sector_erasing;
      logic [fws_pkg::DATA_W-1:0] last_status;
   } fws_ctrl_s;

   fws_ctrl_s s_reg;
   fws_ctrl_s s_next;
   logic bus_ack;
   logic [fws_pkg::DATA_W-1:0] bus_rdata;
   logic done;
   logic [2:0] rd_cnt;

   // States that drive a write cycle rather than a read
   function automatic logic is_write(input fws_pkg::fws_state_e st);
      is_write = (st == fws_pkg::ST_CMD_WR) || (st == fws_pkg::ST_RST_WR) ||
                 (st == fws_pkg::ST_USER_WR);
   endfunction : is_write

   // Toggle bit unchanged between two reads; other bits are not trusted
   function automatic logic same_toggle(input logic [7:0] a,
                                        input logic [7:0] b);
      same_toggle = a[fws_pkg::BIT_OPTOG] == b[fws_pkg::BIT_OPTOG];
   endfunction : same_toggle

   ////////////////////////////////////////////////////////////////////////
   // One bus cycle is issued per state; done marks its answer
   assign done = s_reg.issued && bus_ack;

   always_comb begin
      s_next = s_reg;
      s_next.req = 1'b0;
      s_next.op_done = 1'b0;
      s_next.op_failed = 1'b0;
      s_next.add_done = 1'b0;
      s_next.add_rejected = 1'b0;
      // Stop request only honoured after the second read of a pair
      if (stop_poll && s_reg.polling) begin
         s_next.stop = 1'b1;
      end
      if (s_reg.st != fws_pkg::ST_IDLE && !s_reg.issued) begin
         s_next.req = 1'b1;
         s_next.issued = 1'b1;
         s_next.we = is_write(s_reg.st);
      end
      if (done) begin
         s_next.issued = 1'b0;
      end
      case (s_reg.st)
         fws_pkg::ST_IDLE: begin
            s_next.stop = 1'b0;
            s_next.issued = 1'b0;
            if (start_poll) begin
               // Polling address is held for the whole procedure
               s_next.addr = poll_addr;
               s_next.st = fws_pkg::ST_TG_RD1;
               s_next.busy = 1'b1;
               s_next.polling = 1'b1;
            end else if (add_sector) begin
               s_next.addr = cmd_addr;
               s_next.wdata = cmd_data;
               s_next.st = fws_pkg::ST_WIN_PRE;
               s_next.busy = 1'b1;
            end else if (write_req) begin
               s_next.addr = cmd_addr;
               s_next.wdata = cmd_data;
               s_next.st = fws_pkg::ST_USER_WR;
               s_next.busy = 1'b1;
            end
         end
         fws_pkg::ST_TG_RD1: begin
            if (done) begin
               s_next.first = bus_rdata;
               s_next.last_status = bus_rdata;
               s_next.st = fws_pkg::ST_TG_RD2;
            end
         end
         fws_pkg::ST_TG_RD2: begin
            if (done) begin
               s_next.last_status = bus_rdata;
               // Sector bit toggles only within sectors marked for erase
               s_next.sector_erasing = s_reg.first[fws_pkg::BIT_SECTOG] ^
                                       bus_rdata[fws_pkg::BIT_SECTOG];
               if (same_toggle(s_reg.first, bus_rdata)) begin
                  s_next.op_done = 1'b1;
                  s_next.busy = 1'b0;
                  s_next.polling = 1'b0;
                  s_next.st = fws_pkg::ST_IDLE;
               end else if (bus_rdata[fws_pkg::BIT_TIMEOUT]) begin
                  // Toggle may have stopped just as the flag rose
                  s_next.first = bus_rdata;
                  s_next.st = fws_pkg::ST_TG_RD3;
               end else if (s_reg.stop || stop_poll) begin
                  // Leaving means the next start begins at a fresh pair
                  s_next.busy = 1'b0;
                  s_next.polling = 1'b0;
                  s_next.st = fws_pkg::ST_IDLE;
               end else begin
                  s_next.st = fws_pkg::ST_TG_RD1;
               end
            end
         end
         fws_pkg::ST_TG_RD3: begin
            if (done) begin
               s_next.last_status = bus_rdata;
               if (same_toggle(s_reg.first, bus_rdata)) begin
                  s_next.op_done = 1'b1;
                  s_next.busy = 1'b0;
                  s_next.polling = 1'b0;
                  s_next.st = fws_pkg::ST_IDLE;
               end else begin
                  s_next.addr = fws_pkg::RESET_ADDR;
                  s_next.wdata = fws_pkg::CMD_RESET;
                  s_next.polling = 1'b0;
                  s_next.st = fws_pkg::ST_RST_WR;
               end
            end
         end
         fws_pkg::ST_RST_WR: begin
            if (done) begin
               s_next.op_failed = 1'b1;
               s_next.busy = 1'b0;
               s_next.st = fws_pkg::ST_IDLE;
            end
         end
         fws_pkg::ST_WIN_PRE: begin
            if (done) begin
               s_next.first = bus_rdata;
               // Window already closed: the device would drop the command
               if (bus_rdata[fws_pkg::BIT_WINDOW]) begin
                  s_next.add_done = 1'b1;
                  s_next.add_rejected = 1'b1;
                  s_next.busy = 1'b0;
                  s_next.st = fws_pkg::ST_IDLE;
               end else begin
                  s_next.st = fws_pkg::ST_CMD_WR;
               end
            end
         end
         fws_pkg::ST_CMD_WR: begin
            if (done) begin
               s_next.st = fws_pkg::ST_WIN_POST;
            end
         end
         fws_pkg::ST_WIN_POST: begin
            // Always checked, so add spacing need not be guaranteed
            if (done) begin
               s_next.add_done = 1'b1;
               s_next.add_rejected = bus_rdata[fws_pkg::BIT_WINDOW];
               s_next.last_status = bus_rdata;
               s_next.busy = 1'b0;
               s_next.st = fws_pkg::ST_IDLE;
            end
         end
         fws_pkg::ST_USER_WR: begin
            if (done) begin
               s_next.busy = 1'b0;
               s_next.st = fws_pkg::ST_IDLE;
            end
         end
         default: begin
            s_next.st = fws_pkg::ST_IDLE;
            s_next.busy = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle engine
   fws_bus u_bus (
      .clk(clk),
      .resetn(resetn),
      .req(s_reg.req),
      .req_we(s_reg.we),
      .req_addr(s_reg.addr),
      .req_data(s_reg.wdata),
      .ack(bus_ack),
      .rdata(bus_rdata),
      .ce_n(flash_ce_n),
      .oe_n(flash_oe_n),
      .we_n(flash_we_n),
      .addr(flash_addr),
      .dq_out(flash_dq_out),
      .dq_oe(flash_dq_oe),
      .dq_in(flash_dq_in)
   );

   assign busy = s_reg.busy;
   assign op_done = s_reg.op_done;
   assign op_failed = s_reg.op_failed;
   assign add_done = s_reg.add_done;
   assign add_rejected = s_reg.add_rejected;
   assign sector_erasing = s_reg.sector_erasing;
   assign last_status = s_reg.last_status;

   ////////////////////////////////////////////////////////////////////////
   // Reads since the poll started, only watched by the checks below
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_cnt <= 3'h0;
      end else if (s_reg.st == fws_pkg::ST_IDLE && start_poll) begin
         rd_cnt <= 3'h0;
      end else if (done && s_reg.polling && rd_cnt != fws_pkg::RD_CNT_MAX) begin
         rd_cnt <= rd_cnt + 3'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   two_reads_a: assert property (op_done |-> rd_cnt >= 3'h2)
      else $error("completion reported before two reads");
   fail_recheck_a: assert property (op_failed |-> rd_cnt >= 3'h3)
      else $error("failure reported without a recheck read");
   fail_reset_a: assert property (
      (s_reg.st == fws_pkg::ST_RST_WR && done) |=> op_failed && !busy)
      else $error("reset write did not end in failure report");
   reset_cmd_a: assert property (
      (s_reg.st == fws_pkg::ST_RST_WR && s_reg.req) |->
      s_reg.wdata == fws_pkg::CMD_RESET && s_reg.we ##1 !flash_we_n)
      else $error("reset command not a write of F0");
   stop_exit_a: assert property (
      (s_reg.polling && stop_poll) |-> ##[1:18] !s_reg.polling)
      else $error("polling did not stop in time");
   poll_addr_a: assert property (
      (s_reg.req && s_reg.polling) |-> ##1 flash_addr == $past(s_reg.addr))
      else $error("poll read not at the latched address");
   window_pre_a: assert property (
      (s_reg.st == fws_pkg::ST_CMD_WR && s_reg.req) |->
      !s_reg.first[fws_pkg::BIT_WINDOW])
      else $error("sector added with window closed");
   window_post_a: assert property (
      (s_reg.st == fws_pkg::ST_WIN_POST && done) |=>
      add_done && add_rejected == $past(bus_rdata[fws_pkg::BIT_WINDOW]))
      else $error("window recheck not reported");

   poll_ok_c: cover property (op_done);
   poll_fail_c: cover property (op_failed);
   add_ok_c: cover property (add_done && !add_rejected);
   add_rej_c: cover property (add_done && add_rejected);
endmodule : fws_ctrl
`default_nettype wire

// ### core/fws_pkg.sv
// Shared constants and types for the flash write-status polling controller
`default_nettype none
package fws_pkg;
   // Bus widths of the byte-wide flash
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;

   // Clock and strobe timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_ACC_NS = 90;
   localparam int T_WP_NS = 45;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] ACC_LAST = 4'(ACC_CYC - 1);
   localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);

   // Reset command: one write of this byte to any address
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 17'h00000;

   // Status bit positions on the data bus
   localparam int BIT_POLL = 7;
   localparam int BIT_OPTOG = 6;
   localparam int BIT_TIMEOUT = 5;
   localparam int BIT_WINDOW = 3;
   localparam int BIT_SECTOG = 2;

   // Helper read counter saturation value
   localparam logic [2:0] RD_CNT_MAX = 3'h7;

   // Controller sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_TG_RD1 = 4'h1,
      ST_TG_RD2 = 4'h2,
      ST_TG_RD3 = 4'h3,
      ST_RST_WR = 4'h4,
      ST_WIN_PRE = 4'h5,
      ST_CMD_WR = 4'h6,
      ST_WIN_POST = 4'h7,
      ST_USER_WR = 4'h8
   } fws_state_e;

   // Bus cycle engine states
   typedef enum logic [1:0] {
      BS_IDLE = 2'h0,
      BS_ACT = 2'h1,
      BS_END = 2'h2
   } fws_bus_state_e;
endpackage : fws_pkg
`default_nettype wire

// ### tb/flash_write_status_reporting_test.sv
// Self-checking bench for the write-status polling controller
`timescale 1ns/1ns
`default_nettype none
module flash_write_status_reporting_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic start_poll = 1'b0;
   logic stop_poll = 1'b0;
   logic add_sector = 1'b0;
   logic write_req = 1'b0;
   logic [16:0] poll_addr = 17'h08010; // Program address
   logic [16:0] cmd_addr = 17'h00000;
   logic [7:0] cmd_data = 8'h00;
   logic busy, op_done, op_failed, add_done, add_rejected, sector_erasing;
   logic [7:0] last_status, dq_out, dq_in, wr_data;
   logic ce_n, oe_n, we_n, dq_oe;
   logic [16:0] fl_addr, wr_addr;
   logic m_load = 1'b0;
   logic m_arr = 1'b0;
   logic [7:0] m_n = 8'h00;
   logic m_fail = 1'b0, m_sec = 1'b0, m_wpre = 1'b0, m_wpost = 1'b0;
   logic seen_done, seen_fail, seen_add, seen_rej;
   int rd_cnt, wr_cnt, err_total = 0, check_count = 0, exp_rd;
   logic fail_exp;
   logic [7:0] p_n [6] = '{8'h00, 8'h01, 8'h04, 8'h01, 8'hC8, 8'h03};
   logic p_f [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic p_s [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   // Case 2 stands for a protected target that falls back to array data
   logic p_a [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic a_pre [3] = '{1'b1, 1'b0, 1'b0};
   logic a_post [3] = '{1'b0, 1'b0, 1'b1};

   always #(fws_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

   fws_ctrl u_fws_ctrl (.clk(clk), .resetn(resetn), .start_poll(start_poll),
      .poll_addr(poll_addr), .stop_poll(stop_poll), .add_sector(add_sector),
      .write_req(write_req), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .busy(busy), .op_done(op_done), .op_failed(op_failed),
      .add_done(add_done), .add_rejected(add_rejected),
      .sector_erasing(sector_erasing), .last_status(last_status),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_addr(fl_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_in));

   fws_flash_model u_fws_flash_model (.clk(clk), .load(m_load), .n_act(m_n),
      .fail(m_fail), .sec(m_sec), .to_arr(m_arr), .win_pre(m_wpre),
      .win_post(m_wpost),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fl_addr), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt),
      .wr_addr(wr_addr), .wr_data(wr_data));

   ////////////////////////////////////////////////////////////////////////
   // Catch one-cycle pulses at the settled falling edge
   always @(negedge clk) begin
      if (op_done === 1'b1) seen_done <= 1'b1;
      if (op_failed === 1'b1) seen_fail <= 1'b1;
      if (add_done === 1'b1) begin
         seen_add <= 1'b1;
         seen_rej <= add_rejected;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // Load the device with an operation profile
   task automatic arm(input logic [7:0] n, input logic f, input logic s,
                      input logic wp, input logic wq);
      m_n = n;
      m_fail = f;
      m_sec = s;
      m_wpre = wp;
      m_wpost = wq;
      m_load = 1'b1;
      @(negedge clk);
      m_load = 1'b0;
   endtask : arm

   // One request pulse, then a bounded wait for busy to drop
   task automatic run(input int kind);
      int n;
      seen_done = 1'b0;
      seen_fail = 1'b0;
      seen_add = 1'b0;
      seen_rej = 1'b0;
      start_poll = (kind == 0);
      add_sector = (kind == 1);
      write_req = (kind == 2);
      @(negedge clk);
      start_poll = 1'b0;
      add_sector = 1'b0;
      write_req = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) chk("busy release", busy, 0);
      @(negedge clk);
   endtask : run

   // Watchdog sized well above the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      chk("busy after reset", busy, 0);
      chk("chip select after reset", ce_n, 1);
      // Toggle polling: finish, late finish, recheck pass, timeout failure
      for (int i = 0; i < 6; i++) begin
         m_arr = p_a[i];
         arm(p_n[i], p_f[i], p_s[i], 1'b0, 1'b0);
         run(0);
         fail_exp = p_f[i] && (p_n[i] > 8'h01);
         exp_rd = p_f[i] ? 3 : 2 * ((p_n[i] + 1) / 2 + 1);
         chk("status reads", rd_cnt, exp_rd);
         chk("done pulse", seen_done, !fail_exp);
         chk("failed pulse", seen_fail, fail_exp);
         chk("sector erasing", sector_erasing, p_s[i]);
         chk("reset writes", wr_cnt, fail_exp);
         if (fail_exp) begin
            chk("reset data", wr_data, fws_pkg::CMD_RESET);
            chk("reset addr", wr_addr, fws_pkg::RESET_ADDR);
         end
         // Last byte read: array data, or the polling bit of the status
         if (p_a[i]) begin
            chk("array data", last_status, 8'h5A);
         end else begin
            chk("polling bit", last_status[fws_pkg::BIT_POLL],
                !fail_exp);
         end
         $display("test poll case %0d finished", i);
      end
      // Leave polling early, then resume from a fresh double read
      m_arr = 1'b0;
      arm(8'h09, 1'b0, 1'b0, 1'b0, 1'b0);
      stop_poll = 1'b1;
      run(0);
      stop_poll = 1'b0;
      chk("reads before exit", rd_cnt, 2);
      chk("no failure on exit", seen_fail, 0);
      run(0);
      chk("reads after resume", rd_cnt, 12);
      chk("done after resume", seen_done, 1);
      $display("test stop and resume finished");
      // Sector add with window flag checked before and after
      for (int i = 0; i < 3; i++) begin
         arm(8'h00, 1'b0, 1'b0, a_pre[i], a_post[i]);
         cmd_addr = 17'h08000;
         cmd_data = 8'h30;
         run(1);
         chk("add done", seen_add, 1);
         chk("add rejected", seen_rej, a_pre[i] | a_post[i]);
         chk("add writes", wr_cnt, !a_pre[i]);
         $display("test sector add case %0d finished", i);
      end
      // Plain command write
      arm(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
      cmd_addr = 17'h1ABCD;
      cmd_data = 8'hA5;
      run(2);
      chk("command writes", wr_cnt, 1);
      chk("command addr", wr_addr, 17'h1ABCD);
      chk("command data", wr_data, 8'hA5);
      $display("test command write finished");
      results();
   end
endmodule : flash_write_status_reporting_test
`default_nettype wire

// ### tb/fws_flash_model.sv
// Behavioural byte-wide flash answering status reads and strobe writes
`timescale 1ns/1ns
`default_nettype none
module fws_flash_model #(
   parameter logic [7:0] ARRAY_DATA = 8'h5A
) (
   input wire logic clk,
   input wire logic load,
   input wire logic [7:0] n_act,
   input wire logic fail,
   input wire logic sec,
   input wire logic to_arr,
   input wire logic win_pre,
   input wire logic win_post,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [fws_pkg::ADDR_W-1:0] addr,
   input wire logic [fws_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   output logic [fws_pkg::DATA_W-1:0] dq_in,
   output var int rd_cnt,
   output var int wr_cnt,
   output logic [fws_pkg::ADDR_W-1:0] wr_addr,
   output logic [fws_pkg::DATA_W-1:0] wr_data
);
   logic status = 1'b0;
   logic tog = 1'b0;
   logic sec_tog = 1'b0;
   logic rd_prev = 1'b0;
   logic wr_prev = 1'b0;
   logic [7:0] left = 8'h00;
   logic [7:0] val;
   logic [7:0] last = 8'h00;
   logic rd_on;

   ////////////////////////////////////////////////////////////////////////
   // Status byte; unused bits move each read so nobody can rely on them
   always_comb begin
      val = ARRAY_DATA;
      if (status) begin
         val = {3'h0, rd_cnt[0], 2'h0, rd_cnt[2:1]};
         val[fws_pkg::BIT_POLL] = (left == 8'h00);
         val[fws_pkg::BIT_OPTOG] = tog;
         val[fws_pkg::BIT_TIMEOUT] = fail;
         val[fws_pkg::BIT_WINDOW] = win_pre;
         if (wr_cnt > 0) begin
            val[fws_pkg::BIT_WINDOW] = win_post;
         end
         val[fws_pkg::BIT_SECTOG] = sec_tog;
      end
   end

   // Deselected bus shows the inverse of the last byte, never a stale copy
   assign rd_on = !ce_n && !oe_n;
   assign dq_in = rd_on ? val : ~last;

   ////////////////////////////////////////////////////////////////////////
   // End of each read or write cycle updates the device state
   always @(posedge clk) begin
      rd_prev <= rd_on;
      wr_prev <= !ce_n && !we_n;
      if (load) begin
         status <= 1'b1;
         tog <= 1'b0;
         sec_tog <= 1'b0;
         left <= n_act; // Run length, skipped sectors included
         rd_cnt <= 0;
         wr_cnt <= 0;
      end else begin
         if (rd_prev && !rd_on) begin
            rd_cnt <= rd_cnt + 1;
            last <= val;
            if (status && left != 8'h00) begin
               tog <= !tog;
               left <= left - 8'h01;
            end
            // Protected target: toggling ends by dropping back to array data
            if (status && to_arr && left == 8'h01) begin
               status <= 1'b0;
            end
            if (status && sec) begin
               sec_tog <= !sec_tog;
            end
         end
         if (wr_prev && we_n && dq_oe) begin
            wr_cnt <= wr_cnt + 1;
            wr_addr <= addr;
            wr_data <= dq_out;
            if (dq_out == fws_pkg::CMD_RESET) begin
               status <= 1'b0;
            end
         end
      end
   end
endmodule : fws_flash_model
`default_nettype wire
